// >>> boot_host.sv
`timescale 1ns/1ps
`default_nettype none
module boot_host
(
	input  wire logic mclk_in,
	input  wire logic kick_in,
	input  wire logic lvl_in,
	output logic      external_reset_n_out = 1'b0,
	output logic      pin_out = 1'b0
);
	always @(posedge mclk_in)
	begin
		pin_out  <= lvl_in;
		external_reset_n_out <= !kick_in;
	end
endmodule : boot_host
`default_nettype wire

// >>> loader_entry_pkg.sv
package loader_entry_pkg;

	// Interface selections of the serial loader link
	typedef enum logic [2:0]
	{
		link_none_type_val = 3'h0,
		link_uart          = 3'h1,
		link_i2c           = 3'h2,
		link_can           = 3'h4
	} link_sel_type;

	localparam int unsigned hash_bits = 256;

	// Static configuration presented at boot
	typedef struct packed
	{
		logic loader_enable;
		logic fast_boot;
		logic entry_level;
	} boot_cfg_type;

	// Boot-time facts about the stored image
	typedef struct packed
	{
		logic vector_blank;
		logic stack_blank;
		logic sw_entry_command;
	} boot_facts_type;

	// Cycles the entry pin must be stable after reset release
	localparam logic [3:0] settle_cycles = 4'h4;
	localparam logic [3:0] settle_zero   = 4'h0;

endpackage : loader_entry_pkg

// >>> loader_entry_sva.sv
`timescale 1ns/1ps
`default_nettype none
module loader_entry_sva import loader_entry_pkg::*;
(
	input wire logic mclk_in, external_reset_n_in, loader_entry_request_in,
	input wire boot_cfg_type boot_cfg_in,
	input wire boot_facts_type boot_facts_in,
	input wire link_sel_type link_sel_in,
	input wire logic hash_valid_in, loader_done_in, boot_done_out,
	input wire logic loader_active_out, run_application_out,
	input wire logic access_granted_out, uart_enable_out,
	input wire logic i2c_enable_out, can_enable_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!external_reset_n_in);
	wire logic [2:0] c = boot_cfg_in;
	wire logic [2:0] f = boot_facts_in;
	wire logic ent = c[2] && ((!c[1] && loader_entry_request_in == c[0])
		|| f[2] && f[1] || f[0]);
	// Slack of two edges for the pin synchroniser
	sequence settle_s;
		!boot_done_out[*5] ##[1:3] boot_done_out;
	endsequence
	decide_time_a:
	assert property ($rose(external_reset_n_in) |-> settle_s) else $error("late decision");
	entry_cause_a:
	assert property ($rose(boot_done_out) |-> loader_active_out == ent)
		else $error("wrong entry decision");
	loader_off_a:
	assert property (!c[2] |-> !loader_active_out) else $error("loader on");
	one_outcome_a:
	assert property (boot_done_out |-> loader_active_out ^ run_application_out)
		else $error("outcome not unique");
	link_route_a:
	assert property ($rose(loader_active_out) |=> {can_enable_out,
		i2c_enable_out, uart_enable_out} == link_sel_in) else $error("link");
	grant_scope_a:
	assert property (access_granted_out |-> loader_active_out)
		else $error("grant outside loader");
	grant_cause_a:
	assert property ($rose(access_granted_out) |-> $past(hash_valid_in))
		else $error("grant without hash");
	loader_exit_a:
	assert property (loader_active_out && loader_done_in |=>
		run_application_out && !access_granted_out) else $error("exit");
	reset_clear_a:
	assert property (disable iff (1'b0) !external_reset_n_in |=> !boot_done_out
		&& !loader_active_out) else $error("outputs not cleared");
endmodule : loader_entry_sva
bind serial_boot_loader loader_entry_sva i_sva (.*);
`default_nettype wire

// >>> serial_boot_loader.sv
`timescale 1ns/1ps
`default_nettype none

module serial_boot_loader
	import loader_entry_pkg::*;
(
	input  wire logic                 mclk_in,
	input  wire logic                 external_reset_n_in,
	input  wire logic                 loader_entry_request_in,
	input  wire boot_cfg_type         boot_cfg_in,
	input  wire boot_facts_type       boot_facts_in,
	input  wire link_sel_type         link_sel_in,
	input  wire logic                 hash_valid_in,
	input  wire logic [hash_bits-1:0] hash_presented_in,
	input  wire logic [hash_bits-1:0] hash_stored_in,
	input  wire logic                 loader_done_in,
	output logic                      boot_done_out,
	output logic                      loader_active_out,
	output logic                      run_application_out,
	output logic                      access_granted_out,
	output logic                      uart_enable_out,
	output logic                      i2c_enable_out,
	output logic                      can_enable_out
);

	typedef enum logic [3:0]
	{
		st_settle = 4'h1,
		st_decide = 4'h2,
		st_loader = 4'h4,
		st_app    = 4'h8
	} boot_state_type;

	typedef struct packed
	{
		boot_state_type state;
		logic [3:0]     settle;
		logic           pin_meta;
		logic           pin_sync;
		logic           boot_done;
		logic           loader_active;
		logic           run_app;
		logic           granted;
		logic           uart_en;
		logic           i2c_en;
		logic           can_en;
	} state_type;

	state_type cur;
	state_type next_cur;
	logic      entry;

	// Routed link test, used once per link kind
	function automatic logic link_match
	(
		input link_sel_type sel,
		input link_sel_type code
	);
		return (sel == code);
	endfunction : link_match

	// only the selected link is routed while the loader runs
	function automatic state_type route_links
	(
		input state_type    s,
		input link_sel_type sel
	);
		state_type r;
		r         = s;
		r.uart_en = link_match(sel, link_uart);
		r.i2c_en  = link_match(sel, link_i2c);
		r.can_en  = link_match(sel, link_can);
		return r;
	endfunction : route_links

	// Full-width compare; a partial match must never unlock
	function automatic logic hash_match
	(
		input logic [hash_bits-1:0] presented,
		input logic [hash_bits-1:0] stored
	);
		return (presented == stored);
	endfunction : hash_match

	// Pin, blank image and software command causes, ORed
	function automatic logic entry_cause
	(
		input boot_cfg_type   cfg,
		input boot_facts_type facts,
		input logic           pin
	);
		logic pin_hit;
		logic blank_hit;
		pin_hit   = !cfg.fast_boot && (pin == cfg.entry_level);
		blank_hit = facts.vector_blank && facts.stack_blank;
		return pin_hit || blank_hit || facts.sw_entry_command;
	endfunction : entry_cause

	// Leaving relocks; a new session needs a reboot
	function automatic state_type leave_loader
	(
		input state_type s
	);
		state_type r;
		r               = s;
		r.state         = st_app;
		r.loader_active = 1'b0;
		r.granted       = 1'b0;
		r.uart_en       = 1'b0;
		r.i2c_en        = 1'b0;
		r.can_en        = 1'b0;
		r.run_app       = 1'b1;
		return r;
	endfunction : leave_loader

	always_comb
	begin
		next_cur = cur;
		next_cur.pin_meta = loader_entry_request_in;
		next_cur.pin_sync = cur.pin_meta;
		entry = entry_cause(boot_cfg_in, boot_facts_in, cur.pin_sync)
			&& boot_cfg_in.loader_enable;
		unique case (cur.state)
			st_settle:
			begin
				// wait for pin to pass the synchroniser
				if (cur.settle == settle_zero)
					next_cur.state = st_decide;
				else
					next_cur.settle = cur.settle - 4'h1;
			end
			st_decide:
			begin
				// One decision per reset
				next_cur.boot_done = 1'b1;
				if (entry)
				begin
					next_cur.state         = st_loader;
					next_cur.loader_active = 1'b1;
				end
				else
				begin
					next_cur.state   = st_app;
					next_cur.run_app = 1'b1;
				end
			end
			st_loader:
			begin
				next_cur = route_links(next_cur, link_sel_in);
				if (hash_valid_in
					&& hash_match(hash_presented_in, hash_stored_in))
					next_cur.granted = 1'b1;
				if (loader_done_in)
				begin
					// Done wins over a grant in the same cycle
					next_cur = leave_loader(next_cur);
				end
			end
			st_app:
			begin
				// Stays here until the next reset
				next_cur.run_app = 1'b1;
			end
			default:
			begin
				// Illegal code, restart the boot check
				next_cur.state = st_settle;
			end
		endcase
	end

	// every reset restarts the entry check
	always_ff @(posedge mclk_in)
	begin
		if (!external_reset_n_in)
		begin
			cur.state         <= st_settle;
			cur.settle        <= settle_cycles;
			cur.pin_meta      <= 1'b0;
			cur.pin_sync      <= 1'b0;
			cur.boot_done     <= 1'b0;
			cur.loader_active <= 1'b0;
			cur.run_app       <= 1'b0;
			cur.granted       <= 1'b0;
			cur.uart_en       <= 1'b0;
			cur.i2c_en        <= 1'b0;
			cur.can_en        <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	// Outputs straight from the state register
	assign boot_done_out       = cur.boot_done;
	assign loader_active_out   = cur.loader_active;
	assign run_application_out = cur.run_app;
	assign access_granted_out  = cur.granted;
	assign uart_enable_out     = cur.uart_en;
	assign i2c_enable_out      = cur.i2c_en;
	assign can_enable_out      = cur.can_en;

endmodule : serial_boot_loader

`default_nettype wire

// >>> tb_serial_boot_loader.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_boot_loader import loader_entry_pkg::*;;
	logic clk = 0, kick = 1, lvl = 0, hv = 0, done = 0, e, external_reset_n, pin;
	logic bd, la, ra, ag, ue, ie, ce;
	boot_cfg_type cfg = '0;
	boot_facts_type fx = '0;
	link_sel_type ls = link_uart;
	logic [hash_bits-1:0] hp = '0, hs = '0;
	int fails = 0, comparisons = 0, cyc = 0;
	always #2.5 clk = !clk;
	boot_host i_host (.mclk_in(clk), .kick_in(kick), .lvl_in(lvl),
		.external_reset_n_out(external_reset_n), .pin_out(pin));
	serial_boot_loader i_dut (.mclk_in(clk), .external_reset_n_in(external_reset_n),
		.loader_entry_request_in(pin), .boot_cfg_in(cfg), .boot_facts_in(fx),
		.link_sel_in(ls), .hash_valid_in(hv), .hash_presented_in(hp),
		.hash_stored_in(hs), .loader_done_in(done), .boot_done_out(bd),
		.loader_active_out(la), .run_application_out(ra),
		.access_granted_out(ag), .uart_enable_out(ue), .i2c_enable_out(ie),
		.can_enable_out(ce));
	task chk(string n, logic [2:0] x, logic [2:0] s);
		comparisons++;
		if (s !== x)
		begin
			$display("MISMATCH %s exp %h got %h", n, x, s);
			fails++;
		end
	endtask : chk
	task end_sim;
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	function logic want(boot_cfg_type c, boot_facts_type f, logic p);
		return c.loader_enable && ((!c.fast_boot && p == c.entry_level)
			|| (f.vector_blank && f.stack_blank) || f.sw_entry_command);
	endfunction : want
	initial
	begin
		void'($urandom(41));
		repeat (16) @(posedge clk);
		for (int i = 0; i < 40; i++)
		begin
			kick <= 1;
			repeat (2) @(posedge clk);
			// Corners: blank and software causes but disabled, fast boot with pin match
			{cfg, fx, lvl} <= i == 0 ? 7'h3f : i == 1 ? 7'h71 : 7'($urandom);
			ls <= link_sel_type'(3'h1 << $urandom_range(2));
			hs <= {8{$urandom}};
			@(posedge clk);
			kick <= 0;
			repeat (12) @(posedge clk);
			e = want(cfg, fx, lvl);
			chk("boot_done", 3'h1, 3'(bd));
			chk("loader_active", 3'(e), 3'(la));
			chk("run_application", 3'(!e), 3'(ra));
			chk("links", e ? ls : 3'h0, {ce, ie, ue});
			// Wrong hash then right hash, back to back
			hv <= 1;
			hp <= ~hs;
			@(posedge clk);
			hp <= hs;
			#1 chk("granted_bad", 3'h0, 3'(ag));
			@(posedge clk);
			hv <= 0;
			done <= 1;
			#1 chk("granted", 3'(e), 3'(ag));
			@(posedge clk);
			done <= 0;
			#1 chk("exit", 3'h1, {ag, la, ra});
		end
		end_sim;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_sim;
		end
	end
endmodule : tb_serial_boot_loader
`default_nettype wire
